// ---- inc/dram_mode_pkg.sv ----
// Shared constants and carrier types for the mode setup block
package dram_mode_pkg;

  // Pin widths
  localparam int BA_W   = 3;
  localparam int ADDR_W = 14;
  localparam int LAT_W  = 5;

  // Bank codes that pick a mode register on a mode register set
  localparam logic [2:0] BA_DLL_DRIVER   = 3'h1;
  localparam logic [2:0] BA_REFRESH_LAT  = 3'h2;
  localparam logic [2:0] BA_CALIB_RDOUT  = 3'h3;

  // DLL/driver setup register fields
  localparam int DLL_OFF_BIT  = 0;
  localparam int POSTED_LSB   = 3;
  localparam int WR_LEVEL_BIT = 7;

  // Refresh/latency setup register fields
  localparam int PAR_LSB  = 0;
  localparam int WCD_LSB  = 3;
  localparam int ARR_BIT  = 6;
  localparam int RTS_BIT  = 7;
  localparam int WTERM_LSB = 9;

  // Calibration readout setup register fields
  localparam int PSEL_LSB = 0;
  localparam int PEN_BIT  = 2;

  // Write column delay in cycles for field code zero
  localparam logic [LAT_W-1:0] WCD_BASE = 5'h05;

  // Posted command delay codes
  localparam logic [1:0] PCD_OFF   = 2'h0;
  localparam logic [1:0] PCD_MIN1  = 2'h1;
  localparam logic [1:0] PCD_MIN2  = 2'h2;

  // Reset values of the stored fields
  localparam logic [2:0] PAR_RST   = 3'h0;
  localparam logic [2:0] WCD_RST   = 3'h0;
  localparam logic [1:0] WTERM_RST = 2'h0;
  localparam logic [1:0] PSEL_RST  = 2'h0;
  localparam logic [1:0] PCD_RST   = 2'h0;

  typedef struct packed {
    logic              cke;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_t;

  typedef struct packed {
    logic       dll_off;
    logic [1:0] posted_code;
    logic       wr_level;
    logic [2:0] par_region;
    logic [2:0] wcd_code;
    logic       arr_en;
    logic       rts_ext;
    logic [1:0] wterm_code;
    logic       pattern_en;
    logic [1:0] pattern_sel;
  } mode_cfg_t;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_MRS, CMD_READ, CMD_SR_ENTER, CMD_OTHER
  } cmd_kind_t;

endpackage

// ---- src/pin_sync.sv ----
// Two-stage synchroniser for the command and address pins
`timescale 1ns/10ps
module pin_sync
  import dram_mode_pkg::*;
(
  input  wire logic      sys_clk_in,
  input  wire logic      rst_n_in,
  input  wire cmd_pins_t pins_in,
  output cmd_pins_t      pins_out
);

  localparam cmd_pins_t IDLE_PINS = '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1,
                                      cas_n: 1'b1, we_n: 1'b1,
                                      ba: '0, addr: '0};

  cmd_pins_t stage1_r;
  cmd_pins_t stage1_nxt;
  cmd_pins_t stage2_r;
  cmd_pins_t stage2_nxt;

  always_comb begin
    stage1_nxt = pins_in;
    stage2_nxt = stage1_r;
  end

  // Reset to a deselected bus so nothing decodes while held
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1_r <= IDLE_PINS;
      stage2_r <= IDLE_PINS;
    end else begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
    end
  end

  assign pins_out = stage2_r;

endmodule

// ---- src/dram_mode_setup.sv ----
// Mode register decode, latency math and DLL-off handling
//
// Contract
// - Bank code 2 on MRS loads refresh setup
// - Address bits 3..5 give write column delay
// - Total write delay is posted plus column
// - Retention rate: sensor, else temperature bit
// - Partial retention loses data on self refresh
// - Write termination from bits 9,10; leveling blocks
// - Bank code 3 on MRS loads calibration setup
// - Bit 2 enables pattern; else select ignored
// - Reads return calibration pattern when enabled
// - No-op and deselect register no command
// - DLL/driver bit 0 selects DLL-off mode
// - DLL-off supports read/write delay of six
// - DLL-off read strobe starts one earlier
// - Posted delay codes: off, minus one, two
`timescale 1ns/10ps
module dram_mode_setup
  import dram_mode_pkg::*;
(
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  input  wire cmd_pins_t        pins_in,
  input  wire logic [LAT_W-1:0] read_col_delay_in,
  input  wire logic             thermal_hot_in,
  output mode_cfg_t             mode_cfg_out,
  output logic [LAT_W-1:0]      total_write_delay_out,
  output logic [LAT_W-1:0]      strobe_start_out,
  output logic                  dll_off_out,
  output logic                  fast_retention_out,
  output logic [1:0]            write_term_out,
  output logic                  in_self_refresh_out,
  output logic                  retention_loss_out,
  output logic                  read_pattern_out,
  output logic                  read_array_out,
  output logic [1:0]            pattern_sel_out,
  output logic                  mrs_seen_out
);

  cmd_pins_t pins_s;

  pin_sync u_pin_sync (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .pins_in    (pins_in),
    .pins_out   (pins_s)
  );

  // Posted command delay in cycles from its code and the read delay
  function automatic logic [LAT_W-1:0] posted_cycles(
    input logic [1:0]       code,
    input logic [LAT_W-1:0] rcd
  );
    logic [LAT_W-1:0] res;
    res = '0;
    case (code)
      PCD_MIN1: res = rcd - 5'h01;
      PCD_MIN2: res = rcd - 5'h02;
      default:  res = '0;
    endcase
    return res;
  endfunction

  localparam mode_cfg_t CFG_RST = '{dll_off: 1'b0, posted_code: PCD_RST,
                                    wr_level: 1'b0, par_region: PAR_RST,
                                    wcd_code: WCD_RST, arr_en: 1'b0,
                                    rts_ext: 1'b0, wterm_code: WTERM_RST,
                                    pattern_en: 1'b0,
                                    pattern_sel: PSEL_RST};

  cmd_kind_t        cmd_kind;
  logic             cke_prev_r;
  logic             cke_prev_nxt;
  mode_cfg_t        cfg_r;
  mode_cfg_t        cfg_nxt;
  logic             sr_r;
  logic             sr_nxt;
  logic             loss_r;
  logic             loss_nxt;
  logic [LAT_W-1:0] twd_r;
  logic [LAT_W-1:0] twd_nxt;
  logic [LAT_W-1:0] strobe_r;
  logic [LAT_W-1:0] strobe_nxt;
  logic             fast_r;
  logic             fast_nxt;
  logic [1:0]       wterm_r;
  logic [1:0]       wterm_nxt;
  logic             rd_pat_r;
  logic             rd_pat_nxt;
  logic             rd_arr_r;
  logic             rd_arr_nxt;
  logic             mrs_r;
  logic             mrs_nxt;

  // Command decode; MRS and read registered only with CKE high the cycle before
  // No-op, deselect ignored
  always_comb begin
    cmd_kind = CMD_NONE;
    if (!pins_s.cs_n) begin
      case ({pins_s.ras_n, pins_s.cas_n, pins_s.we_n})
        3'b000:  cmd_kind = cke_prev_r ? CMD_MRS : CMD_NONE;
        3'b101:  cmd_kind = cke_prev_r ? CMD_READ : CMD_NONE;
        3'b001:  cmd_kind = (cke_prev_r && !pins_s.cke) ? CMD_SR_ENTER
                                                          : CMD_OTHER;
        3'b111:  cmd_kind = CMD_NONE;
        default: cmd_kind = CMD_OTHER;
      endcase
    end
  end

  // Mode register loads; untouched registers keep their fields
  always_comb begin
    cfg_nxt = cfg_r;
    mrs_nxt = 1'b0;
    if (cmd_kind == CMD_MRS) begin
      mrs_nxt = 1'b1;
      case (pins_s.ba)
        BA_DLL_DRIVER: begin
          cfg_nxt.dll_off     = pins_s.addr[DLL_OFF_BIT];
          cfg_nxt.posted_code = pins_s.addr[POSTED_LSB +: 2];
          cfg_nxt.wr_level    = pins_s.addr[WR_LEVEL_BIT];
        end
        BA_REFRESH_LAT: begin
          cfg_nxt.par_region = pins_s.addr[PAR_LSB +: 3];
          cfg_nxt.wcd_code   = pins_s.addr[WCD_LSB +: 3];
          cfg_nxt.arr_en     = pins_s.addr[ARR_BIT];
          cfg_nxt.rts_ext    = pins_s.addr[RTS_BIT];
          cfg_nxt.wterm_code = pins_s.addr[WTERM_LSB +: 2];
        end
        BA_CALIB_RDOUT: begin
          cfg_nxt.pattern_en  = pins_s.addr[PEN_BIT];
          cfg_nxt.pattern_sel = pins_s.addr[PSEL_LSB +: 2];
        end
        // Other targets leave these fields alone
        default: cfg_nxt = cfg_r;
      endcase
    end
  end

  // Derived latencies and policy outputs
  always_comb begin
    twd_nxt = posted_cycles(cfg_r.posted_code, read_col_delay_in)
              + WCD_BASE + {2'h0, cfg_r.wcd_code};
    strobe_nxt = posted_cycles(cfg_r.posted_code, read_col_delay_in)
                 + read_col_delay_in - {4'h0, cfg_r.dll_off};
    fast_nxt = cfg_r.arr_en ? thermal_hot_in : cfg_r.rts_ext;
    wterm_nxt = cfg_r.wr_level ? 2'h0 : cfg_r.wterm_code;
  end

  // Self refresh tracking and read steering
  always_comb begin
    cke_prev_nxt = pins_s.cke;
    sr_nxt       = sr_r;
    loss_nxt     = loss_r;
    rd_pat_nxt   = 1'b0;
    rd_arr_nxt   = 1'b0;
    if (cmd_kind == CMD_SR_ENTER) begin
      sr_nxt = 1'b1;
      if (cfg_r.par_region != PAR_RST) begin
        loss_nxt = 1'b1;
      end
    end else if (sr_r && pins_s.cke) begin
      sr_nxt = 1'b0;
    end
    // Loss flag clears once a full-array setting is stored again
    if (cfg_r.par_region == PAR_RST && cmd_kind != CMD_SR_ENTER) begin
      loss_nxt = 1'b0;
    end
    if (cmd_kind == CMD_READ) begin
      rd_pat_nxt = cfg_r.pattern_en;
      rd_arr_nxt = !cfg_r.pattern_en;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cke_prev_r <= 1'b0;
      cfg_r      <= CFG_RST;
      sr_r       <= 1'b0;
      loss_r     <= 1'b0;
      twd_r      <= '0;
      strobe_r   <= '0;
      fast_r     <= 1'b0;
      wterm_r    <= 2'h0;
      rd_pat_r   <= 1'b0;
      rd_arr_r   <= 1'b0;
      mrs_r      <= 1'b0;
    end else begin
      cke_prev_r <= cke_prev_nxt;
      cfg_r      <= cfg_nxt;
      sr_r       <= sr_nxt;
      loss_r     <= loss_nxt;
      twd_r      <= twd_nxt;
      strobe_r   <= strobe_nxt;
      fast_r     <= fast_nxt;
      wterm_r    <= wterm_nxt;
      rd_pat_r   <= rd_pat_nxt;
      rd_arr_r   <= rd_arr_nxt;
      mrs_r      <= mrs_nxt;
    end
  end

  // Select bits ignored while the pattern store is off
  logic [1:0] psel_r;
  logic [1:0] psel_nxt;

  always_comb begin
    psel_nxt = cfg_nxt.pattern_en ? cfg_nxt.pattern_sel : PSEL_RST;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      psel_r <= PSEL_RST;
    end else begin
      psel_r <= psel_nxt;
    end
  end

  // Every output is a register bit or a registered word
  assign mode_cfg_out          = cfg_r;
  assign total_write_delay_out = twd_r;
  assign strobe_start_out      = strobe_r;
  assign dll_off_out           = cfg_r.dll_off;
  assign fast_retention_out    = fast_r;
  assign write_term_out        = wterm_r;
  assign in_self_refresh_out   = sr_r;
  assign retention_loss_out    = loss_r;
  assign read_pattern_out      = rd_pat_r;
  assign read_array_out        = rd_arr_r;
  assign pattern_sel_out       = psel_r;
  assign mrs_seen_out          = mrs_r;

endmodule

// ---- tb/dram_mode_setup_properties.sv ----
// Port-level checks for the mode setup block
`timescale 1ns/10ps
module dram_mode_chk
  import dram_mode_pkg::*;
(
  input wire logic             sys_clk_in,
  input wire logic             rst_n_in,
  input wire cmd_pins_t        pins_in,
  input wire logic [LAT_W-1:0] read_col_delay_in,
  input wire logic             thermal_hot_in,
  input wire mode_cfg_t        mode_cfg_out,
  input wire logic [LAT_W-1:0] total_write_delay_out,
  input wire logic             fast_retention_out,
  input wire logic             read_pattern_out,
  input wire logic             read_array_out,
  input wire logic [1:0]       pattern_sel_out,
  input wire logic             mrs_seen_out,
  input wire logic             in_self_refresh_out
);
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic [2:0]       rcw;
  logic             cke_q, live, mrs_ok, rd_ok;
  logic [LAT_W-1:0] al;
  assign rcw = {pins_in.ras_n, pins_in.cas_n, pins_in.we_n};
  assign live = !pins_in.cs_n && pins_in.cke && cke_q;
  assign mrs_ok = live && rcw == 3'h0;
  assign rd_ok = live && rcw == 3'h5;
  assign al = mode_cfg_out.posted_code == PCD_MIN1 ? read_col_delay_in - 5'h01
    : mode_cfg_out.posted_code == PCD_MIN2 ? read_col_delay_in - 5'h02
    : 5'h00;
  // Reset low like the design's sync stage, so no command counts early
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      cke_q <= 1'b0;
    else
      cke_q <= pins_in.cke;
  chk_idle_quiet: assert property (
    pins_in.cs_n || rcw == 3'h7 |-> ##3 !(mrs_seen_out || read_array_out))
    else $error("pulse after idle pins");
  chk_mrs_pulse: assert property (
    mrs_ok |-> ##3 mrs_seen_out) else $error("mode set not seen");
  chk_wcd_load: assert property (
    mrs_ok && pins_in.ba == BA_REFRESH_LAT
    |-> ##3 mode_cfg_out.wcd_code == $past(pins_in.addr[5:3], 3))
    else $error("write column code not loaded");
  chk_write_sum: assert property (
    $past(rst_n_in) |->
    total_write_delay_out == $past(WCD_BASE + mode_cfg_out.wcd_code + al))
    else $error("total write delay wrong");
  chk_rate_source: assert property (
    $past(rst_n_in) |-> fast_retention_out == $past(mode_cfg_out.arr_en
    ? thermal_hot_in : mode_cfg_out.rts_ext))
    else $error("self refresh rate source wrong");
  chk_read_source: assert property (
    rd_ok |-> ##3 read_pattern_out == $past(mode_cfg_out.pattern_en)
    && read_array_out == !$past(mode_cfg_out.pattern_en))
    else $error("read answered from wrong source");
  chk_field_hold: assert property (
    !mrs_seen_out |-> $stable(mode_cfg_out))
    else $error("fields changed without mode set");
  chk_sel_gate: assert property (
    !mode_cfg_out.pattern_en |-> pattern_sel_out == 2'h0)
    else $error("pattern select leaks when disabled");
  cover property (mrs_ok ##3 mrs_seen_out);
  cover property (read_pattern_out);
  cover property ($rose(in_self_refresh_out));
endmodule

bind dram_mode_setup dram_mode_chk CHK (
  .sys_clk_in            (sys_clk_in),
  .rst_n_in              (rst_n_in),
  .pins_in               (pins_in),
  .read_col_delay_in     (read_col_delay_in),
  .thermal_hot_in        (thermal_hot_in),
  .mode_cfg_out          (mode_cfg_out),
  .total_write_delay_out (total_write_delay_out),
  .fast_retention_out    (fast_retention_out),
  .read_pattern_out      (read_pattern_out),
  .read_array_out        (read_array_out),
  .pattern_sel_out       (pattern_sel_out),
  .mrs_seen_out          (mrs_seen_out),
  .in_self_refresh_out   (in_self_refresh_out)
);

// ---- tb/ctrl_model.sv ----
// Controller model driving the command and address pins
`timescale 1ns/10ps
module ctrl_model
  import dram_mode_pkg::*;
(
  input  wire logic sys_clk_in,
  output cmd_pins_t pins_out
);
  initial pins_out = '{cke: 1'b1, cs_n: 1'b1, default: '0};
  function automatic logic [13:0] legal(logic [2:0] ba, logic [13:0] a);
    if (ba == BA_REFRESH_LAT)
      return a & 14'h06ff;
    if (ba == BA_CALIB_RDOUT)
      return a & 14'h0007;
    return a;
  endfunction
  task automatic issue(input logic k, input logic [2:0] rcw, ba,
                       input logic [13:0] a);
    @(posedge sys_clk_in);
    #1;
    pins_out.cke = k;
    pins_out.cs_n = 1'b0;
    {pins_out.ras_n, pins_out.cas_n, pins_out.we_n} = rcw;
    pins_out.ba = ba;
    pins_out.addr = legal(ba, a);
    @(posedge sys_clk_in);
    #1;
    // Deselected lines show the inverse so stale values cannot pass
    pins_out.cs_n = 1'b1;
    pins_out.ba = ~pins_out.ba;
    pins_out.addr = ~pins_out.addr;
  endtask
endmodule

// ---- tb/test_dram_mode_setup.sv ----
// Self-checking bench for the mode setup block
`timescale 1ns/10ps
module test_dram_mode_setup
  import dram_mode_pkg::*;
;
  logic             sys_clk_in = 1'b0;
  logic             rst_n_in = 1'b0;
  logic [LAT_W-1:0] rcd = 5'h06;
  logic             hot = 1'b0;
  logic [LAT_W-1:0] twd, strb;
  logic [1:0]       wterm, psel;
  logic             dll, fast, sr, loss, rpat, rarr, mrs;
  cmd_pins_t        pins;
  mode_cfg_t        cfg;
  int               errors = 0;
  int               total_checks = 0;
  typedef struct {
    logic [2:0]  ba;
    logic [13:0] a;
    logic [4:0]  wd, st;
    logic        dl;
  } row_t;
  // Mode sets and the latencies they give at a read column delay of six
  row_t rows[9] = '{
    '{3'h1, 14'h0000, 5'h05, 5'h06, 1'b0},
    '{3'h2, 14'h0008, 5'h06, 5'h06, 1'b0},
    '{3'h1, 14'h0008, 5'h0b, 5'h0b, 1'b0},
    '{3'h1, 14'h0010, 5'h0a, 5'h0a, 1'b0},
    '{3'h1, 14'h0018, 5'h06, 5'h06, 1'b0},
    '{3'h1, 14'h0001, 5'h06, 5'h05, 1'b1},
    '{3'h2, 14'h0138, 5'h0c, 5'h05, 1'b1},
    '{3'h6, 14'h3fff, 5'h0c, 5'h05, 1'b1},
    '{3'h7, 14'h3fff, 5'h0c, 5'h05, 1'b1}
  };
  ctrl_model CTRL (.sys_clk_in(sys_clk_in), .pins_out(pins));
  dram_mode_setup DUT (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .pins_in(pins),
    .read_col_delay_in(rcd), .thermal_hot_in(hot), .mode_cfg_out(cfg),
    .total_write_delay_out(twd), .strobe_start_out(strb),
    .dll_off_out(dll), .fast_retention_out(fast), .write_term_out(wterm),
    .in_self_refresh_out(sr), .retention_loss_out(loss),
    .read_pattern_out(rpat), .read_array_out(rarr),
    .pattern_sel_out(psel), .mrs_seen_out(mrs));
  initial forever #5 sys_clk_in = ~sys_clk_in;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Returns in the one cycle in which the command's pulses stand
  task automatic cmd(input logic k, input logic [2:0] rcw, ba,
                     input logic [13:0] a);
    CTRL.issue(k, rcw, ba, a);
    repeat (2) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic settle();
    @(posedge sys_clk_in);
    #1;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk_in);
    #1;
    rst_n_in = 1'b1;
    foreach (rows[i]) begin
      cmd(1'b1, 3'h0, rows[i].ba, rows[i].a);
      check(mrs, 1);
      settle();
      check(twd, rows[i].wd);
      check(strb, rows[i].st);
      check(dll, rows[i].dl);
    end
    cmd(1'b1, 3'h0, 3'h2, 14'h0008);
    cmd(1'b1, 3'h0, 3'h1, 14'h0001);
    settle();
    check(twd, 6);
    check(strb, 5);
    // Posted delay must track a changed read column delay
    rcd = 5'h08;
    cmd(1'b1, 3'h0, 3'h1, 14'h0010);
    settle();
    check(twd, 5'h0c);
    check(strb, 5'h0e);
    rcd = 5'h06;
    cmd(1'b1, 3'h0, 3'h2, 14'h0680);
    settle();
    check(fast, 1);
    check(wterm, 3);
    cmd(1'b1, 3'h0, 3'h1, 14'h0080);
    settle();
    check(wterm, 0);
    hot = 1'b1;
    cmd(1'b1, 3'h0, 3'h2, 14'h0040);
    settle();
    check(fast, 1);
    hot = 1'b0;
    settle();
    check(fast, 0);
    // Sensor on: the temperature bit must be ignored
    cmd(1'b1, 3'h0, 3'h2, 14'h00c0);
    settle();
    check(fast, 0);
    // Banks idle; reads with pattern off, then on
    cmd(1'b1, 3'h0, 3'h3, 14'h0003);
    check(psel, 0);
    cmd(1'b1, 3'h5, 3'h0, 14'h0000);
    check(rarr, 1);
    cmd(1'b1, 3'h0, 3'h3, 14'h0006);
    check(psel, 2);
    cmd(1'b1, 3'h5, 3'h0, 14'h0000);
    check(rpat, 1);
    check(rarr, 0);
    cmd(1'b1, 3'h0, 3'h3, 14'h0000);
    cmd(1'b1, 3'h7, 3'h2, 14'h0038);
    check(mrs, 0);
    check(cfg.wcd_code, 0);
    cmd(1'b1, 3'h0, 3'h2, 14'h0001);
    cmd(1'b0, 3'h1, 3'h0, 14'h0000);
    settle();
    check(sr, 1);
    check(loss, 1);
    cmd(1'b1, 3'h7, 3'h0, 14'h0000);
    settle();
    check(sr, 0);
    cmd(1'b1, 3'h0, 3'h2, 14'h0000);
    settle();
    check(loss, 0);
    rst_n_in = 1'b0;
    settle();
    check(cfg, 0);
    check(twd, 0);
    // Second release: the first command must land as after power-up
    rst_n_in = 1'b1;
    cmd(1'b1, 3'h0, 3'h2, 14'h0008);
    check(mrs, 1);
    settle();
    check(twd, 6);
    summarize();
  end
endmodule
